/* src/rssm_consts.svh */
// constants for the reset source and supply monitor block
// Summary of operation
// - bit 7 enables digital monitor, resets to 1
// - bit 6 shows live digital reset level
// - bit 5 shows digital warning level
// - bit 4 enables digital warning interrupt
// - bit 3 enables battery monitor, resets 0
// - bit 2 shows battery reset level
// - bit 1 shows battery warning level
// - bit 0 enables battery warning interrupt
// - low pin resets, sets pin cause flag
// - clock stuck over 100 us resets
// - cause bit 2 enables clock-loss, flags it
// - clock-loss off in suspend and sleep
// - cause bit 5 makes comparator reset source
// - comparator flag reads 1 only after it
// - comparator in low power needs wake enable
// - watchdog enabled, core clock over 12
// - missed watchdog service resets, sets flag
// - watchdog off in suspend and sleep
// - illegal flash accesses reset the device
// - flash error sets cause bit 6
// - only power-fail reset drives reset pin
// - power reset re-enables digital, disables battery
`ifndef RSSM_CONSTS_SVH
`define RSSM_CONSTS_SVH

// ---------------------------------------------------------------
// register bus and map
// ---------------------------------------------------------------
`define RSSM_ADDR_W        8
`define RSSM_DATA_W        8
`define RSSM_SMC_ADDR      8'hff
`define RSSM_RCR_ADDR      8'hef
`define RSSM_WDC_ADDR      8'h20

// ---------------------------------------------------------------
// field positions and reset values
// ---------------------------------------------------------------
`define RSSM_SMC_DIG_EN    7
`define RSSM_SMC_DIG_RST   6
`define RSSM_SMC_DIG_WARN  5
`define RSSM_SMC_DIG_IE    4
`define RSSM_SMC_BAT_EN    3
`define RSSM_SMC_BAT_RST   2
`define RSSM_SMC_BAT_WARN  1
`define RSSM_SMC_BAT_IE    0
`define RSSM_RCR_PIN       0
`define RSSM_RCR_PWR       1
`define RSSM_RCR_CLK       2
`define RSSM_RCR_WDG       3
`define RSSM_RCR_CMP       5
`define RSSM_RCR_FLS       6
`define RSSM_RCR_RESET     8'h02
`define RSSM_WDC_EN        0
`define RSSM_WDC_KICK      1

// ---------------------------------------------------------------
// timing
// ---------------------------------------------------------------
`define RSSM_CLK_PERIOD_NS 20
`define RSSM_CLK_LOSS_NS   100000
`define RSSM_CLK_LOSS_CYCLES (`RSSM_CLK_LOSS_NS / `RSSM_CLK_PERIOD_NS)
`define RSSM_WDOG_DIV      12
`define RSSM_WDOG_LIMIT    65535
`define RSSM_HOLD_CYCLES   16

// ---------------------------------------------------------------
// synchroniser lanes
// ---------------------------------------------------------------
`define RSSM_NSYNC         7
`define RSSM_SY_PIN        0
`define RSSM_SY_CMP        1
`define RSSM_SY_DRST       2
`define RSSM_SY_DWARN      3
`define RSSM_SY_BRST       4
`define RSSM_SY_BWARN      5
`define RSSM_SY_CLKMON     6

`endif

/* src/rssm_pkg.sv */
// types for the reset source and supply monitor block
package rssm_pkg;

  // reset sequencer states
  typedef enum logic [1:0] {
    rssm_run,
    rssm_hold,
    rssm_stretch
  } rssm_state_t;

endpackage

/* src/rssm_src_if.sv */
// interface between the sequencer and its timed reset sources
`timescale 1ns/1ps
interface rssm_src_if;
  logic run;        // high while the system is out of reset
  logic cl_en;      // effective clock-loss enable
  logic mon_level;  // synchronised watched clock level
  logic cl_fire;    // clock-loss timeout
  logic wd_en;      // effective watchdog enable
  logic wd_kick;    // one-cycle service pulse
  logic wd_fire;    // watchdog timeout

  modport top      (output run, cl_en, mon_level, wd_en, wd_kick, input cl_fire, wd_fire);
  modport clk_loss (input run, cl_en, mon_level, output cl_fire);
  modport wdog     (input run, wd_en, wd_kick, output wd_fire);
endinterface // rssm_src_if

/* src/rssm_clk_loss.sv */
// clock-loss detector: times how long the watched clock holds one level
`timescale 1ns/1ps
`include "rssm_consts.svh"
module rssm_clk_loss #(
  parameter int unsigned CYCLES = `RSSM_CLK_LOSS_CYCLES,
  parameter int unsigned CNT_W  = 16
) (
  input  wire logic    clock_i,
  input  wire logic    rstn_i,
  rssm_src_if.clk_loss src
);
  localparam logic [CNT_W-1:0] LIM = CNT_W'(CYCLES);

  logic             last_q;  // previous sample of the watched level
  logic [CNT_W-1:0] cnt_q;   // cycles without a level change
  logic             fire_q;  // timeout, held until reset drops run

  // ---------------------------------------------------------------
  // level history
  // ---------------------------------------------------------------
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) last_q <= 1'b0;
    else         last_q <= src.mon_level;
  end

  // any edge restarts the count; saturates so it cannot wrap to zero
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) cnt_q <= '0;
    else if (!src.run || !src.cl_en || (src.mon_level != last_q)) cnt_q <= '0;
    else if (cnt_q != LIM) cnt_q <= cnt_q + 1'b1;
  end

  // stuck for the full window: request reset
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) fire_q <= 1'b0;
    else         fire_q <= src.run && src.cl_en && (cnt_q == LIM);
  end

  assign src.cl_fire = fire_q;
endmodule // rssm_clk_loss

/* src/rssm_wdog.sv */
// watchdog: core clock divided by twelve, service clears the count
`timescale 1ns/1ps
`include "rssm_consts.svh"
module rssm_wdog #(
  parameter int unsigned LIMIT = `RSSM_WDOG_LIMIT,
  parameter int unsigned CNT_W = 16
) (
  input  wire logic clock_i,
  input  wire logic rstn_i,
  rssm_src_if.wdog  src
);
  localparam logic [3:0]       DIV_LAST = 4'(`RSSM_WDOG_DIV - 1);
  localparam logic [CNT_W-1:0] LIM      = CNT_W'(LIMIT);

  logic [3:0]       pre_q;  // prescaler
  logic [CNT_W-1:0] cnt_q;  // timeout count in prescaled ticks
  logic             fire_q; // timeout request
  logic             tick;   // one pulse every twelve cycles

  assign tick = (pre_q == DIV_LAST);

  // ---------------------------------------------------------------
  // prescaler, restarted with every service so timing is repeatable
  // ---------------------------------------------------------------
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) pre_q <= '0;
    else if (!src.run || !src.wd_en || src.wd_kick || tick) pre_q <= '0;
    else pre_q <= pre_q + 1'b1;
  end

  // timeout counter
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) cnt_q <= '0;
    else if (!src.run || !src.wd_en || src.wd_kick) cnt_q <= '0;
    else if (tick && (cnt_q != LIM)) cnt_q <= cnt_q + 1'b1;
  end

  // service missed: request reset
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) fire_q <= 1'b0;
    else         fire_q <= src.run && src.wd_en && (cnt_q == LIM);
  end

  assign src.wd_fire = fire_q;
endmodule // rssm_wdog

/* src/rssm_top.sv */
// reset sequencer, cause register and supply monitor control
//
// The strobed register port is this design's own decision.
`timescale 1ns/1ps
`include "rssm_consts.svh"
module rssm_top #(
  parameter int unsigned CLK_LOSS_CYCLES = `RSSM_CLK_LOSS_CYCLES,
  parameter int unsigned WDOG_LIMIT      = `RSSM_WDOG_LIMIT,
  parameter int unsigned HOLD_CYCLES     = `RSSM_HOLD_CYCLES,
  parameter int unsigned FLASH_AW        = 17
) (
  input  wire logic                    clock_i,
  input  wire logic                    rstn_i,
  // register port
  input  wire logic [`RSSM_ADDR_W-1:0] addr_i,
  input  wire logic [`RSSM_DATA_W-1:0] wdata_i,
  input  wire logic                    wr_i,
  input  wire logic                    rd_i,
  output logic      [`RSSM_DATA_W-1:0] rdata_o,
  // analog and pin inputs, asynchronous
  input  wire logic                    rst_pin_i,
  input  wire logic                    comparator_out_i,
  input  wire logic                    digital_rst_cmp_i,
  input  wire logic                    digital_warn_cmp_i,
  input  wire logic                    battery_rst_cmp_i,
  input  wire logic                    battery_warn_cmp_i,
  input  wire logic                    core_clock_mon_i,
  // power state and wake setup, same clock
  input  wire logic                    suspend_i,
  input  wire logic                    sleep_i,
  input  wire logic                    comparator_wake_i,
  // flash access monitor, same clock
  input  wire logic                    flash_write_i,
  input  wire logic                    flash_write_enable_i,
  input  wire logic                    code_read_i,
  input  wire logic                    branch_i,
  input  wire logic                    flash_secure_block_i,
  input  wire logic [FLASH_AW-1:0]     flash_addr_i,
  input  wire logic [FLASH_AW-1:0]     lock_addr_i,
  // outputs
  output logic                         sys_rst_o,
  output logic                         rst_pin_o,
  output logic                         rst_pin_oen_o,
  output logic                         digital_warn_irq_o,
  output logic                         battery_warn_irq_o
);
  localparam logic [4:0] HOLD_LAST = 5'(HOLD_CYCLES - 1);

  // ---------------------------------------------------------------
  // input synchronisers
  // ---------------------------------------------------------------
  logic [`RSSM_NSYNC-1:0] async_in;  // raw asynchronous inputs
  logic [`RSSM_NSYNC-1:0] sy1_q;     // first stage, read only by sy2_q
  logic [`RSSM_NSYNC-1:0] sy2_q;     // safe to use

  assign async_in = {core_clock_mon_i, battery_warn_cmp_i, battery_rst_cmp_i,
                     digital_warn_cmp_i, digital_rst_cmp_i, comparator_out_i, rst_pin_i};

  // one two-stage chain per lane; pin and supply idle high
  genvar g;
  generate
    for (g = 0; g < `RSSM_NSYNC; g++) begin : g_sync
      always_ff @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i) begin
          sy1_q[g] <= 1'b1;
          sy2_q[g] <= 1'b1;
        end else begin
          sy1_q[g] <= async_in[g];
          sy2_q[g] <= sy1_q[g];
        end
      end
    end
  endgenerate

  // ---------------------------------------------------------------
  // state declarations
  // ---------------------------------------------------------------
  rssm_pkg::rssm_state_t state_q;    // sequencer state
  logic [4:0]            hold_q;     // stretch counter
  logic [7:0]            cause_q;    // one-hot cause of the reset in flight
  logic [7:0]            flags_q;    // cause flags as read back
  logic                  sys_rst_q;  // system reset request
  logic                  pin_oen_q;  // low while the pin is pulled down
  logic                  dig_en_q;   // digital monitor enable
  logic                  dig_ie_q;   // digital warning interrupt enable
  logic                  bat_en_q;   // battery monitor enable
  logic                  bat_ie_q;   // battery warning interrupt enable
  logic                  pwr_sel_q;  // digital monitor selected as source
  logic                  clk_en_q;   // clock-loss detector enable
  logic                  cmp_en_q;   // comparator reset enable
  logic                  wd_en_q;    // watchdog enable
  logic [7:0]            rdata_q;    // read data, valid one cycle
  logic                  irq_d_q;    // digital warning request
  logic                  irq_b_q;    // battery warning request

  logic       low_power;  // suspend or sleep
  logic       pin_src;    // external pin reset active
  logic       pwr_src;    // power-fail reset active
  logic       cmp_src;    // comparator reset active
  logic       fls_src;    // illegal flash access this cycle
  logic [7:0] src_v;      // all sources at cause positions
  logic [7:0] first_v;    // lowest set source, wins the cause
  logic       exit_w;     // last cycle of reset
  logic       wr_smc;     // write to supply monitor control
  logic       wr_rcr;     // write to reset cause register
  logic       wr_wdc;     // write to watchdog control
  logic       above_lock; // flash address past the lock byte
  logic [7:0] smc_rd;     // supply monitor control read value
  logic [7:0] rcr_rd;     // reset cause read value

  rssm_src_if src_if ();

  // ---------------------------------------------------------------
  // reset sources
  // ---------------------------------------------------------------
  assign low_power = suspend_i | sleep_i;

  // the pin is ignored while we pull it, so our own drive cannot re-trigger
  assign pin_src = ~sy2_q[`RSSM_SY_PIN] & pin_oen_q;
  // supply monitors are off in sleep, so the power-fail reset is too
  assign pwr_src = dig_en_q & pwr_sel_q & ~sy2_q[`RSSM_SY_DRST] & ~sleep_i;
  // comparator resets while plus is below minus (output low)
  assign cmp_src = cmp_en_q & ~sy2_q[`RSSM_SY_CMP]
                 & (~low_power | comparator_wake_i);
  assign above_lock = flash_addr_i > lock_addr_i;
  assign fls_src = (flash_write_i & flash_write_enable_i & above_lock)
                 | (code_read_i & above_lock)
                 | (branch_i & above_lock)
                 | flash_secure_block_i
                 | (flash_write_i & ~dig_en_q);

  always_comb begin
    src_v                 = 8'h00;
    src_v[`RSSM_RCR_PIN]  = pin_src;
    src_v[`RSSM_RCR_PWR]  = pwr_src;
    src_v[`RSSM_RCR_CLK]  = src_if.cl_fire;
    src_v[`RSSM_RCR_WDG]  = src_if.wd_fire;
    src_v[`RSSM_RCR_CMP]  = cmp_src;
    src_v[`RSSM_RCR_FLS]  = fls_src;
  end

  // isolate the lowest set bit: simultaneous causes resolve by position
  assign first_v = src_v & (8'h00 - src_v);

  // ---------------------------------------------------------------
  // timed sources: clock-loss detector and watchdog
  // ---------------------------------------------------------------
  assign src_if.run       = ~sys_rst_q;
  assign src_if.cl_en     = clk_en_q & ~low_power;
  assign src_if.mon_level = sy2_q[`RSSM_SY_CLKMON];
  assign src_if.wd_en     = wd_en_q & ~low_power;
  assign src_if.wd_kick   = wr_wdc & wdata_i[`RSSM_WDC_KICK];

  rssm_clk_loss #(
    .CYCLES (CLK_LOSS_CYCLES),
    .CNT_W  (16)
  ) u_clk_loss (
    .clock_i (clock_i),
    .rstn_i  (rstn_i),
    .src     (src_if.clk_loss)
  );

  rssm_wdog #(
    .LIMIT (WDOG_LIMIT),
    .CNT_W (16)
  ) u_wdog (
    .clock_i (clock_i),
    .rstn_i  (rstn_i),
    .src     (src_if.wdog)
  );

  // ---------------------------------------------------------------
  // reset sequencer
  // ---------------------------------------------------------------
  assign exit_w = (state_q == rssm_pkg::rssm_stretch) && (src_v == 8'h00)
                && (hold_q == HOLD_LAST);

  // hold while any source is active, then stretch a fixed number of cycles
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      state_q <= rssm_pkg::rssm_run;
      hold_q  <= '0;
    end else begin
      unique case (state_q)
        rssm_pkg::rssm_run: begin
          hold_q <= '0;
          if (src_v != 8'h00) state_q <= rssm_pkg::rssm_hold;
        end
        rssm_pkg::rssm_hold: begin
          hold_q <= '0;
          if (src_v == 8'h00) state_q <= rssm_pkg::rssm_stretch;
        end
        rssm_pkg::rssm_stretch: begin
          if (src_v != 8'h00) begin
            state_q <= rssm_pkg::rssm_hold;
            hold_q  <= '0;
          end else if (hold_q == HOLD_LAST) begin
            state_q <= rssm_pkg::rssm_run;
          end else begin
            hold_q <= hold_q + 1'b1;
          end
        end
      endcase
    end
  end

  // cause is fixed at entry; later pulses do not rename the reset
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) cause_q <= `RSSM_RCR_RESET;
    else if ((state_q == rssm_pkg::rssm_run) && (src_v != 8'h00)) cause_q <= first_v;
  end

  // system reset request, raised on entry and dropped at exit
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) sys_rst_q <= 1'b0;
    else if ((state_q == rssm_pkg::rssm_run) && (src_v != 8'h00)) sys_rst_q <= 1'b1;
    else if (exit_w) sys_rst_q <= 1'b0;
  end

  // only a power-fail reset pulls the pin, and only while the supply is low
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) pin_oen_q <= 1'b1;
    else         pin_oen_q <= ~(pwr_src & (state_q != rssm_pkg::rssm_run));
  end

  // cause flags are rewritten once, on the way out of reset
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) flags_q <= `RSSM_RCR_RESET;
    else if (exit_w) flags_q <= cause_q;
  end

  // ---------------------------------------------------------------
  // register decode
  // ---------------------------------------------------------------
  assign wr_smc = wr_i && (addr_i == `RSSM_SMC_ADDR);
  assign wr_rcr = wr_i && (addr_i == `RSSM_RCR_ADDR);
  assign wr_wdc = wr_i && (addr_i == `RSSM_WDC_ADDR);

  // supply monitor enables: only power resets touch them in hardware
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      dig_en_q <= 1'b1;
      dig_ie_q <= 1'b0;
      bat_en_q <= 1'b0;
      bat_ie_q <= 1'b0;
    end else if (exit_w && cause_q[`RSSM_RCR_PWR]) begin
      dig_en_q <= 1'b1;
      bat_en_q <= 1'b0;
    end else if (wr_smc) begin
      dig_en_q <= wdata_i[`RSSM_SMC_DIG_EN];
      dig_ie_q <= wdata_i[`RSSM_SMC_DIG_IE];
      bat_en_q <= wdata_i[`RSSM_SMC_BAT_EN];
      bat_ie_q <= wdata_i[`RSSM_SMC_BAT_IE];
    end
  end

  // power-fail selection; software must enable the monitor first
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) pwr_sel_q <= 1'b1;
    else if (exit_w && cause_q[`RSSM_RCR_PWR]) pwr_sel_q <= 1'b1;
    else if (wr_rcr) pwr_sel_q <= wdata_i[`RSSM_RCR_PWR];
  end

  // clock-loss and comparator enables start off after every reset
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      clk_en_q <= 1'b0;
      cmp_en_q <= 1'b0;
    end else if (exit_w) begin
      clk_en_q <= 1'b0;
      cmp_en_q <= 1'b0;
    end else if (wr_rcr) begin
      clk_en_q <= wdata_i[`RSSM_RCR_CLK];
      cmp_en_q <= wdata_i[`RSSM_RCR_CMP];
    end
  end

  // watchdog comes back enabled after any reset
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) wd_en_q <= 1'b1;
    else if (exit_w) wd_en_q <= 1'b1;
    else if (wr_wdc) wd_en_q <= wdata_i[`RSSM_WDC_EN];
  end

  // ---------------------------------------------------------------
  // read back
  // ---------------------------------------------------------------
  // battery status reads zero while its monitor is off
  always_comb begin
    smc_rd                     = 8'h00;
    smc_rd[`RSSM_SMC_DIG_EN]   = dig_en_q;
    smc_rd[`RSSM_SMC_DIG_RST]  = sy2_q[`RSSM_SY_DRST];
    smc_rd[`RSSM_SMC_DIG_WARN] = sy2_q[`RSSM_SY_DWARN];
    smc_rd[`RSSM_SMC_DIG_IE]   = dig_ie_q;
    smc_rd[`RSSM_SMC_BAT_EN]   = bat_en_q;
    smc_rd[`RSSM_SMC_BAT_RST]  = bat_en_q & sy2_q[`RSSM_SY_BRST];
    smc_rd[`RSSM_SMC_BAT_WARN] = bat_en_q & sy2_q[`RSSM_SY_BWARN];
    smc_rd[`RSSM_SMC_BAT_IE]   = bat_ie_q;
  end

  // cause bits read the flags, not the enables written there
  always_comb begin
    rcr_rd                = 8'h00;
    rcr_rd[`RSSM_RCR_PIN] = flags_q[`RSSM_RCR_PIN];
    rcr_rd[`RSSM_RCR_PWR] = flags_q[`RSSM_RCR_PWR];
    rcr_rd[`RSSM_RCR_CLK] = flags_q[`RSSM_RCR_CLK];
    rcr_rd[`RSSM_RCR_WDG] = flags_q[`RSSM_RCR_WDG];
    rcr_rd[`RSSM_RCR_CMP] = flags_q[`RSSM_RCR_CMP];
    rcr_rd[`RSSM_RCR_FLS] = flags_q[`RSSM_RCR_FLS];
  end

  // read data stand for one cycle only; unmapped reads return zero
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) rdata_q <= 8'h00;
    else if (!rd_i) rdata_q <= 8'h00;
    else if (addr_i == `RSSM_SMC_ADDR) rdata_q <= smc_rd;
    else if (addr_i == `RSSM_RCR_ADDR) rdata_q <= rcr_rd;
    else if (addr_i == `RSSM_WDC_ADDR) rdata_q <= {7'h00, wd_en_q};
    else rdata_q <= 8'h00;
  end

  // ---------------------------------------------------------------
  // early warning requests to the interrupt controller
  // ---------------------------------------------------------------
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      irq_d_q <= 1'b0;
      irq_b_q <= 1'b0;
    end else begin
      irq_d_q <= dig_ie_q & dig_en_q & ~sy2_q[`RSSM_SY_DWARN];
      irq_b_q <= bat_ie_q & bat_en_q & ~sy2_q[`RSSM_SY_BWARN];
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign rdata_o            = rdata_q;
  assign sys_rst_o          = sys_rst_q;
  assign rst_pin_o          = 1'b0;
  assign rst_pin_oen_o      = pin_oen_q;
  assign digital_warn_irq_o = irq_d_q;
  assign battery_warn_irq_o = irq_b_q;

endmodule // rssm_top

/* dv/rssm_top_assertions.sv */
// port-level checker for the reset source and supply monitor block
`timescale 1ns/1ps
module rssm_top_assertions (
  input wire logic        clock_i, rstn_i, wr_i, rd_i, rst_pin_i, sys_rst_o, rst_pin_oen_o,
  input wire logic        digital_rst_cmp_i, digital_warn_cmp_i, battery_warn_cmp_i,
  input wire logic        code_read_i, flash_secure_block_i,
  input wire logic        digital_warn_irq_o, battery_warn_irq_o,
  input wire logic [7:0]  addr_i, rdata_o,
  input wire logic [16:0] flash_addr_i, lock_addr_i
);
  // ----------------------------------------
  // one clock domain, reset disables all
  // ----------------------------------------
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rstn_i);
  AST_RD_IDLE: assert property (rdata_o != 8'h00 |-> $past(rd_i)) else $error("stray rdata");
  AST_UNMAP: assert property (rd_i && addr_i == 8'h10 |=> rdata_o == 8'h00) else $error("unmap");
  AST_FLASH_RD: assert property (code_read_i && flash_addr_i > lock_addr_i && !sys_rst_o
    |=> sys_rst_o) else $error("no flash reset");
  AST_SECURE: assert property (flash_secure_block_i && !sys_rst_o |=> sys_rst_o)
    else $error("no secure reset");
  AST_PIN: assert property ($fell(rst_pin_i) && rst_pin_oen_o && !sys_rst_o
    |-> ##[1:4] sys_rst_o) else $error("no pin reset");
  AST_PIN_KEEP: assert property (digital_rst_cmp_i [*5] |-> rst_pin_oen_o)
    else $error("pin driven");
  AST_DIG_IRQ: assert property (digital_warn_cmp_i [*5] |-> !digital_warn_irq_o)
    else $error("dig irq");
  AST_BAT_IRQ: assert property (battery_warn_cmp_i [*5] |-> !battery_warn_irq_o)
    else $error("bat irq");
  AST_HOLD: assert property ($rose(sys_rst_o) |-> sys_rst_o [*4]) else $error("short");
endmodule // rssm_top_assertions
bind rssm_top rssm_top_assertions u_chk (.*);

/* dv/reset_source_supply_monitor_tb.sv */
// self-checking bench for the reset source and supply monitor block
`timescale 1ns/1ps
module reset_source_supply_monitor_tb;
  logic clock_i, rstn_i, wr_i, rd_i, rst_pin_i, comparator_out_i, digital_rst_cmp_i, mon_run;
  logic digital_warn_cmp_i, battery_rst_cmp_i, battery_warn_cmp_i, core_clock_mon_i, suspend_i;
  logic sleep_i, comparator_wake_i, flash_write_i, flash_write_enable_i, code_read_i, branch_i;
  logic flash_secure_block_i, sys_rst_o, rst_pin_o, rst_pin_oen_o;
  logic digital_warn_irq_o, battery_warn_irq_o;
  logic [7:0]  addr_i, wdata_i, rdata_o;
  logic [16:0] flash_addr_i, lock_addr_i;
  int          err_total, check_count, cyc;
  // rows: address, write data, expected read back
  logic [23:0] rows [6] = '{24'hff_ff_ff, 24'hff_80_e0, 24'h10_55_00, 24'hef_02_08,
                            24'h20_03_01, 24'h20_00_00};
  // short counts keep the run brief
  rssm_top #(.CLK_LOSS_CYCLES(50), .WDOG_LIMIT(20), .HOLD_CYCLES(4)) u_dut (.*);
  // ----------------------------------------
  // clock, watched clock and hang limit
  // ----------------------------------------
  initial begin
    clock_i = 1'b0;
    forever #10 clock_i = ~clock_i;
  end
  always @(posedge clock_i) begin
    if (mon_run) core_clock_mon_i <= ~core_clock_mon_i;
    cyc++;
    if (cyc == 20000) begin
      err_total++;
      end_of_test();
    end
  end
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    check_count++;
    if (g !== e) begin
      err_total++;
      $display("ERROR %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock_i) {addr_i, wdata_i, wr_i} <= {a, d, 1'b1};
    @(posedge clock_i) wr_i <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge clock_i) {addr_i, rd_i} <= {a, 1'b1};
    @(posedge clock_i) rd_i <= 1'b0;
    #1 chk(rdata_o, e);
  endtask
  // wait out a reset, drop the pin, supply and comparator sources, restart the watched clock, park the watchdog, check the cause
  task automatic rst_wait(input logic [7:0] e);
    int n = 0;
    while (sys_rst_o !== 1'b1 && n < 400) begin @(posedge clock_i); n++; end
    chk(sys_rst_o, 8'h01);
    {rst_pin_i, digital_rst_cmp_i, comparator_out_i, mon_run} <= 4'hf;
    while (sys_rst_o !== 1'b0 && n < 600) begin @(posedge clock_i); n++; end
    chk(sys_rst_o, 8'h00);
    wr(8'h20, 8'h00);
    rd(8'hef, e);
  endtask
  task automatic end_of_test();
    $display("checks %0d errors %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    {rstn_i, wr_i, rd_i, addr_i, wdata_i, mon_run, core_clock_mon_i} = '0;
    {rst_pin_i, comparator_out_i, digital_rst_cmp_i, digital_warn_cmp_i} = 4'hf;
    {battery_rst_cmp_i, battery_warn_cmp_i, suspend_i, sleep_i, comparator_wake_i} = 5'b11000;
    {flash_write_i, flash_write_enable_i, code_read_i, branch_i, flash_secure_block_i} = '0;
    {flash_addr_i, lock_addr_i, err_total, check_count, cyc} = '0;
    lock_addr_i = 17'h0_8000;
    repeat (12) @(posedge clock_i);
    {rstn_i, mon_run} <= 2'b11;
    rd(8'hff, 8'he0);
    rd(8'hef, 8'h02);
    rd(8'h20, 8'h01);
    rst_wait(8'h08);
    foreach (rows[i]) begin
      wr(rows[i][23:16], rows[i][15:8]);
      rd(rows[i][23:16], rows[i][7:0]);
    end
    wr(8'hff, 8'h99);
    {digital_warn_cmp_i, battery_warn_cmp_i} <= 2'b00;
    repeat (6) @(posedge clock_i);
    chk({digital_warn_irq_o, battery_warn_irq_o}, 8'h03);
    wr(8'hff, 8'h88);
    repeat (3) @(posedge clock_i);
    chk({digital_warn_irq_o, battery_warn_irq_o}, 8'h00);
    {digital_warn_cmp_i, battery_warn_cmp_i} <= 2'b11;
    for (int k = 0; k < 4; k++) begin
      @(posedge clock_i) {flash_write_enable_i, flash_addr_i} <= {1'b1, lock_addr_i + 17'h1};
      {flash_write_i, flash_secure_block_i, branch_i, code_read_i} <= 4'h1 << k;
      @(posedge clock_i) {flash_write_i, flash_secure_block_i, branch_i, code_read_i} <= 4'h0;
      rst_wait(8'h40);
    end
    digital_rst_cmp_i <= 1'b0;
    repeat (8) @(posedge clock_i);
    chk({rst_pin_o, rst_pin_oen_o}, 8'h00);
    rst_wait(8'h02);
    rd(8'hff, 8'he0);
    wr(8'hef, 8'h06);
    {suspend_i, mon_run} <= 2'b10;
    repeat (80) @(posedge clock_i);
    chk(sys_rst_o, 8'h00);
    suspend_i <= 1'b0;
    rst_wait(8'h04);
    wr(8'hef, 8'h22);
    {sleep_i, comparator_out_i} <= 2'b10;
    repeat (8) @(posedge clock_i);
    chk(sys_rst_o, 8'h00);
    comparator_wake_i <= 1'b1;
    rst_wait(8'h20);
    {sleep_i, comparator_wake_i} <= 2'b00;
    rst_pin_i <= 1'b0;
    rst_wait(8'h01);
    end_of_test();
  end
endmodule // reset_source_supply_monitor_tb
